// *** dv/i2c_serial_memory_8kx8_test.sv ***
// Self-checking bench of the two-wire memory slave driven by a bus master model.
// Assumes the design's default device type and an 80 ns serial clock.
module i2c_serial_memory_8kx8_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] TYPE_CODE = 4'h5; // Arbitrary, equals the design default
  localparam int CYCLE_LIMIT = 60000;
  logic clk;
  logic reset;
  logic [2:0] device_select_pins;
  logic write_protect;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe_n;
  logic sda_wire;
  logic res_valid;
  logic res_kind;
  logic [7:0] res_val;
  logic [8:0] exp_q[$];
  logic [7:0] ref_mem[logic [12:0]];
  logic [12:0] ptr;
  logic [31:0] lfsr;
  logic [8:0] note;
  int n_fail;
  int samples_checked;
  int cycles;
  // Pulled-up wire: low while either agent pulls it
  assign sda_wire = (sda_low | ~sda_oe_n) ? 1'b0 : 1'b1;
  i2cm_top dut (.clk(clk), .reset(reset), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .device_select_pins(device_select_pins), .write_protect(write_protect));
  i2cm_master_model m (.clk(clk), .sda(sda_wire), .scl(scl), .sda_low(sda_low),
    .res_valid(res_valid), .res_kind(res_kind), .res_val(res_val));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check_bit(input string what, input logic e, input logic s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", what, e, s);
    end
  endtask
  task automatic check_data(input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] read byte expected %h seen %h", e, s);
    end
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  // Eight steps per byte so successive values share no shifted bits
  task automatic rnd(output logic [7:0] v);
    repeat (8) lfsr = lfsr_next(lfsr);
    v = lfsr[31:24] ^ lfsr[7:0];
  endtask
  task automatic sel_byte(input logic [2:0] sel, input logic rd, input logic ack_n);
    exp_q.push_back({1'b0, 7'h00, ack_n});
    m.wr_byte({TYPE_CODE, sel, rd});
  endtask
  task automatic set_ptr(input logic [15:0] a);
    m.start(1'b0);
    sel_byte(device_select_pins, 1'b0, 1'b0);
    exp_q.push_back(9'h000);
    m.wr_byte(a[15:8]);
    exp_q.push_back(9'h000);
    m.wr_byte(a[7:0]);
    ptr = a[12:0];
  endtask
  // acked and advanced even when protected
  task automatic send_data(input int n);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      rnd(d);
      exp_q.push_back(9'h000);
      m.wr_byte(d);
      if (write_protect == 1'b0) ref_mem[ptr] = d;
      ptr = ptr + 13'h0001;
    end
  endtask
  task automatic read_data(input int n, input logic again);
    m.start(again);
    sel_byte(device_select_pins, 1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({1'b1, ref_mem[ptr]});
      m.rd_byte(i == n - 1);
      ptr = ptr + 13'h0001;
    end
    m.stop();
  endtask
  // Oldest note against each reported result; SDA only ever pulled low
  always @(posedge clk) begin
    if (sda_oe_n === 1'b0) check_bit("drive level", 1'b0, sda_out);
    if (res_valid === 1'b1) begin
      if (exp_q.size() == 0) check_bit("result note", 1'b0, 1'b1);
      else begin
        note = exp_q.pop_front();
        check_bit("result kind", note[8], res_kind);
        if (note[8]) check_data(note[7:0], res_val);
        else check_bit("ack", note[0], res_val[0]);
      end
    end
  end
  // Cycle ceiling cuts a hung bus short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_LIMIT) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    logic [7:0] hi;
    logic [7:0] lo;
    logic [15:0] a;
    reset = 1'b1;
    device_select_pins = 3'h0;
    write_protect = 1'b0;
    lfsr = 32'h00008C6A;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    // burst wraps past the top, top address bits set
    set_ptr(16'hFFFE);
    send_data(4);
    m.stop();
    // read straight back via other top bits, then current address
    set_ptr(16'h3FFE);
    read_data(3, 1'b1);
    read_data(1, 1'b0);
    // every select value and a foreign type
    rnd(hi);
    device_select_pins <= hi[2:0];
    repeat (4) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      m.start(1'b0);
      sel_byte(i[2:0], 1'b0, i[2:0] != device_select_pins);
      m.stop();
    end
    m.start(1'b0);
    exp_q.push_back(9'h001);
    m.wr_byte({~TYPE_CODE, device_select_pins, 1'b0});
    m.stop();
    // random places: burst, protected write, aborted byte
    for (int k = 0; k < 4; k++) begin
      rnd(hi);
      rnd(lo);
      a = {hi, lo};
      set_ptr(a);
      send_data(k == 0 ? 20 : 3);
      m.stop();
      write_protect <= 1'b1;
      repeat (4) @(posedge clk);
      set_ptr(a);
      send_data(2);
      m.stop();
      read_data(1, 1'b0);
      // An aborted byte must leave the array alone whatever the protect level
      write_protect <= hi[3];
      repeat (4) @(posedge clk);
      // four bits then START or STOP
      set_ptr(a);
      for (int b = 0; b < 4; b++) m.put_bit(hi[b], lo[0]);
      if (k[0]) m.stop();
      read_data(k == 0 ? 20 : 3, ~k[0]);
      write_protect <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (20) @(posedge clk);
    conclude();
  end
endmodule // i2c_serial_memory_8kx8_test

// *** dv/i2cm_master_model.sv ***
// Bus master model: drives SCL, pulls SDA low, reports each ACK bit and read byte.
// Assumes the bench pulls the SDA wire up and feeds its level back on sda.
module i2cm_master_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  output logic res_valid,
  output logic res_kind,
  output logic [7:0] res_val
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus: clock stands high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_valid = 1'b0;
    res_kind = 1'b0;
    res_val = 8'h00;
  end
  // Result strobe lasts one clock
  always @(posedge clk) begin
    if (res_valid) res_valid <= 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // change low, sample high
  // Data moves in mid-low only, so no bit can pass for START or STOP
  task automatic put_bit(input logic b, output logic seen);
    @(posedge clk) scl <= 1'b0;
    tick(2);
    sda_low <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    seen = sda;
    tick(1);
  endtask
  // Repeated start lets SCL fall first so the slave drops its ACK
  task automatic start(input logic again);
    if (again) begin
      @(posedge clk) scl <= 1'b0;
      tick(2);
      sda_low <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(4);
    end
    @(posedge clk) sda_low <= 1'b1;
    tick(4);
  endtask
  task automatic stop();
    @(posedge clk) scl <= 1'b0;
    tick(2);
    sda_low <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask
  // MSB first, then ninth bit released for the slave's answer
  task automatic wr_byte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i], a);
    put_bit(1'b1, a);
    res_kind <= 1'b0;
    res_val <= {7'h00, a};
    res_valid <= 1'b1;
  endtask
  task automatic rd_byte(input logic last);
    logic [7:0] d;
    logic s;
    d = 8'h00;
    for (int i = 0; i < 8; i++) begin
      put_bit(1'b1, s);
      d = {d[6:0], s};
    end
    put_bit(last, s);
    res_kind <= 1'b1;
    res_val <= d;
    res_valid <= 1'b1;
  endtask
endmodule // i2cm_master_model

// *** verilog/i2cm_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset; DEPTH is a power of two.
module i2cm_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_push;
  logic do_pop;

  // Full and empty come from the occupancy count
  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = store[rd_ptr];
  assign do_push = in_valid & in_ready;
  assign do_pop = out_valid & out_ready;

  // Pointers and count
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + 1'b1;
      if (do_pop) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // Storage needs no reset; only counted entries are ever read
  always_ff @(posedge clk) begin
    if (do_push) store[wr_ptr] <= in_data;
  end

endmodule // i2cm_fifo

// *** verilog/i2cm_pkg.sv ***
// Shared constants and types for the two-wire serial memory slave.
// Assumes one 100 MHz system clock; the serial clock is sampled, not used as a clock.
package i2cm_pkg;

  // Array geometry
  localparam int ADDR_W = 13;
  localparam int MEM_DEPTH = 8192;
  localparam int DATA_W = 8;

  // Write buffer depth
  localparam int FIFO_DEPTH = 16;

  // Bit counter values: last data bit taken, all eight bits sent
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ALL_BITS = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // Slave address byte fields
  localparam int SA_TYPE_HI = 7;
  localparam int SA_TYPE_LO = 4;
  localparam int SA_SEL_HI = 3;
  localparam int SA_SEL_LO = 1;
  localparam int SA_RW = 0;

  // Upper address byte: only its low bits reach the pointer
  localparam int HI_USED_MSB = 4;

  // Pointer step and top of the array
  localparam logic [ADDR_W-1:0] PTR_ONE = 13'h0001;
  localparam logic [ADDR_W-1:0] PTR_LAST = 13'h1FFF;
  localparam logic [ADDR_W-1:0] PTR_RESET = 13'h0000;

  // Synchroniser layout: {write_protect, device_select_pins[2:0], sda, scl}
  localparam int SYNC_W = 6;
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_SEL_LO = 2;
  localparam int SY_SEL_HI = 4;
  localparam int SY_WP = 5;
  // Idle pin levels, so no false SCL or SDA edge follows reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 6'h03;

  // Bus state machine, one-hot
  typedef enum logic [7:0] {
    I2CM_IDLE = 8'h01,
    I2CM_DEVADDR = 8'h02,
    I2CM_ADDRH = 8'h04,
    I2CM_ADDRL = 8'h08,
    I2CM_WDATA = 8'h10,
    I2CM_ACK = 8'h20,
    I2CM_TX = 8'h40,
    I2CM_RACK = 8'h80
  } i2cm_state_t;

  // One buffered array write
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } i2cm_wr_t;

endpackage : i2cm_pkg

// *** verilog/i2cm_top.sv ***
// Slave side of a two-wire serial memory of 8192 bytes with write protect.
// Assumes scl and sda arrive asynchronously and SCL is much slower than clk.
// Function
// RULE_01 - Answer only when slave address select bits equal the select pins.
// RULE_02 - An open select pin reads as logic zero.
// RULE_03 - Change SDA after SCL falls; sample SDA on SCL rising.
// RULE_04 - Drive SDA only low, otherwise release it.
// RULE_05 - With write protect high, no array location changes.
// RULE_06 - With write protect low, every address is writable.
// RULE_07 - An open write protect input reads low, array writable.
// RULE_08 - Array holds 8192 locations of eight bits.
// RULE_09 - Bytes move bit by bit over SDA in both directions.
// RULE_10 - Two memory address bytes follow a write slave address.
// RULE_11 - Top three address bits are ignored.
// RULE_12 - Remaining thirteen bits select one unique location.
// RULE_13 - Array access adds no delay beyond the serial transfer.
// RULE_14 - Never report busy after a write.
// RULE_15 - Writes finish before any following transaction can shift in.
// RULE_16 - Slave address bit zero: one reads, zero writes.
// RULE_17 - Pointer increments before each data acknowledge, wrapping 1FFF to 0000.
// RULE_18 - Master acknowledge fetches next byte; no acknowledge ends the read.
// RULE_19 - Commit after the eighth data bit; START or STOP earlier discards it.
// RULE_20 - Under write protect, still acknowledge and advance, but keep contents.
module i2cm_top #(
  parameter logic [3:0] DEVICE_TYPE = 4'h5 // Arbitrary value
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [2:0] device_select_pins,
  input wire logic write_protect
);
  localparam int WR_W = $bits(i2cm_pkg::i2cm_wr_t);

  logic [i2cm_pkg::SYNC_W-1:0] sync1;
  logic [i2cm_pkg::SYNC_W-1:0] sync2;
  logic scl_d;
  logic sda_d;
  i2cm_pkg::i2cm_state_t state;
  i2cm_pkg::i2cm_state_t ack_next;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic byte_done;
  logic [7:0] addr_hi;
  logic [i2cm_pkg::ADDR_W-1:0] ptr;
  logic [7:0] mem_q;
  logic [7:0] mem [i2cm_pkg::MEM_DEPTH];

  i2cm_pkg::i2cm_state_t next_state;
  i2cm_pkg::i2cm_state_t next_ack;
  logic [3:0] next_cnt;
  logic [7:0] next_sh;
  logic next_done;
  logic next_oe_n;

  // Two flip-flops on every pin before any logic looks at it
  // RULE_02 select pins synchronised
  // RULE_07 protect pin synchronised
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1 <= i2cm_pkg::SYNC_IDLE;
      sync2 <= i2cm_pkg::SYNC_IDLE;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sync1 <= {write_protect, device_select_pins, sda_in, scl};
      sync2 <= sync1;
      scl_d <= sync2[i2cm_pkg::SY_SCL];
      sda_d <= sync2[i2cm_pkg::SY_SDA];
    end
  end

  // Synchronised levels and bus events
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [2:0] dsel_s;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_s = sync2[i2cm_pkg::SY_SCL];
  assign sda_s = sync2[i2cm_pkg::SY_SDA];
  assign wp_s = sync2[i2cm_pkg::SY_WP];
  assign dsel_s = sync2[i2cm_pkg::SY_SEL_HI:i2cm_pkg::SY_SEL_LO];
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  // Byte decode; the byte is complete on the rising edge of its eighth bit
  logic [7:0] rx_byte;
  logic is_rx;
  logic last_bit;
  logic rx_last;
  logic addr_match;
  assign rx_byte = {shreg[6:0], sda_s};
  assign is_rx = (state == i2cm_pkg::I2CM_DEVADDR) | (state == i2cm_pkg::I2CM_ADDRH) |
                 (state == i2cm_pkg::I2CM_ADDRL) | (state == i2cm_pkg::I2CM_WDATA);
  assign last_bit = bit_cnt == i2cm_pkg::LAST_BIT;
  assign rx_last = scl_rise & is_rx & last_bit;
  // RULE_01 type and select bits must both match
  assign addr_match = (rx_byte[i2cm_pkg::SA_TYPE_HI:i2cm_pkg::SA_TYPE_LO] == DEVICE_TYPE) &&
                      (rx_byte[i2cm_pkg::SA_SEL_HI:i2cm_pkg::SA_SEL_LO] == dsel_s);

  // Write buffer handshake; a full buffer turns into a no-acknowledge
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WR_W-1:0] fifo_out_data;
  logic wdata_last;
  logic push_req;
  logic drain_ready;
  logic mem_wr;
  logic ptr_inc;
  i2cm_pkg::i2cm_wr_t push_word;
  i2cm_pkg::i2cm_wr_t drain_word;
  assign wdata_last = rx_last & (state == i2cm_pkg::I2CM_WDATA) & fifo_in_ready;
  // RULE_05 protect high stops the write at its source
  // RULE_06 protect low lets every byte through
  // RULE_19 push only on the eighth bit
  assign push_req = wdata_last & ~wp_s;
  assign push_word = '{addr: ptr, data: rx_byte};
  assign drain_word = fifo_out_data;
  // Array port is shared: transmit keeps read priority so the fetch is never disturbed
  assign drain_ready = state != i2cm_pkg::I2CM_TX;
  assign mem_wr = fifo_out_valid & drain_ready;
  // RULE_17 advance just before each acknowledge
  // RULE_20 advance even when protected
  assign ptr_inc = wdata_last | (scl_rise & (state == i2cm_pkg::I2CM_TX) & last_bit);

  i2cm_fifo #(
    .WIDTH(WR_W),
    .DEPTH(i2cm_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(push_req),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(drain_ready),
    .out_data(fifo_out_data)
  );

  // Bit-level sequencing; START and STOP override any edge
  always_comb begin
    next_state = state;
    next_ack = ack_next;
    next_cnt = bit_cnt;
    next_sh = shreg;
    next_done = byte_done;
    next_oe_n = sda_oe_n;
    if (stop_cond) begin
      next_state = i2cm_pkg::I2CM_IDLE;
      next_done = 1'b0;
      next_oe_n = 1'b1;
    end else if (start_cond) begin
      next_state = i2cm_pkg::I2CM_DEVADDR;
      next_cnt = i2cm_pkg::CNT_ZERO;
      next_done = 1'b0;
      next_oe_n = 1'b1;
    end else if (scl_rise) begin
      // RULE_03 incoming bits taken on the rising edge
      // RULE_09 shift in MSB first
      if (is_rx) begin
        next_sh = rx_byte;
        next_cnt = bit_cnt + i2cm_pkg::CNT_ONE;
        if (last_bit) begin
          next_done = 1'b1;
          case (state)
            i2cm_pkg::I2CM_DEVADDR: begin
              // RULE_01 stay silent on a foreign address
              // RULE_16 direction bit picks read or address phase
              if (!addr_match) begin
                next_state = i2cm_pkg::I2CM_IDLE;
                next_done = 1'b0;
              end else if (rx_byte[i2cm_pkg::SA_RW]) begin
                next_ack = i2cm_pkg::I2CM_TX;
              end else begin
                next_ack = i2cm_pkg::I2CM_ADDRH;
              end
            end
            // RULE_10 two address bytes in turn
            i2cm_pkg::I2CM_ADDRH: next_ack = i2cm_pkg::I2CM_ADDRL;
            i2cm_pkg::I2CM_ADDRL: next_ack = i2cm_pkg::I2CM_WDATA;
            i2cm_pkg::I2CM_WDATA: begin
              // RULE_14 only a full buffer refuses, never a write in progress
              next_ack = i2cm_pkg::I2CM_WDATA;
              if (!fifo_in_ready) begin
                next_state = i2cm_pkg::I2CM_IDLE;
                next_done = 1'b0;
              end
            end
            default: next_done = 1'b0;
          endcase
        end
      end else if (state == i2cm_pkg::I2CM_TX) begin
        next_cnt = bit_cnt + i2cm_pkg::CNT_ONE;
      end else if (state == i2cm_pkg::I2CM_RACK) begin
        // RULE_18 no acknowledge ends the read
        if (sda_s) next_state = i2cm_pkg::I2CM_IDLE;
      end
    end else if (scl_fall) begin
      // RULE_03 outgoing changes only after the falling edge
      if (byte_done) begin
        // RULE_20 acknowledge even while protected
        next_done = 1'b0;
        next_state = i2cm_pkg::I2CM_ACK;
        next_oe_n = 1'b0;
      end else if ((state == i2cm_pkg::I2CM_ACK) || (state == i2cm_pkg::I2CM_RACK)) begin
        next_state = ack_next;
        next_cnt = i2cm_pkg::CNT_ZERO;
        // RULE_18 acknowledged read loads the next byte
        if (ack_next == i2cm_pkg::I2CM_TX) begin
          next_sh = mem_q;
          next_oe_n = mem_q[7];
        end else begin
          next_oe_n = 1'b1;
        end
      end else if (state == i2cm_pkg::I2CM_TX) begin
        if (bit_cnt == i2cm_pkg::ALL_BITS) begin
          next_state = i2cm_pkg::I2CM_RACK;
          next_ack = i2cm_pkg::I2CM_TX;
          next_oe_n = 1'b1;
        end else begin
          // RULE_09 shift out MSB first
          next_sh = {shreg[6:0], 1'b0};
          next_oe_n = shreg[6];
        end
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= i2cm_pkg::I2CM_IDLE;
      ack_next <= i2cm_pkg::I2CM_IDLE;
      bit_cnt <= i2cm_pkg::CNT_ZERO;
      shreg <= 8'h00;
      byte_done <= 1'b0;
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end else begin
      state <= next_state;
      ack_next <= next_ack;
      bit_cnt <= next_cnt;
      shreg <= next_sh;
      byte_done <= next_done;
      sda_oe_n <= next_oe_n;
      // RULE_04 the pad only ever pulls low
      sda_out <= 1'b0;
    end
  end

  // Address pointer; kept across transactions so a read follows the last access
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_hi <= 8'h00;
      ptr <= i2cm_pkg::PTR_RESET;
    end else begin
      if (rx_last && (state == i2cm_pkg::I2CM_ADDRH)) addr_hi <= rx_byte;
      // RULE_11 top three bits dropped
      // RULE_12 thirteen bits form the pointer
      if (rx_last && (state == i2cm_pkg::I2CM_ADDRL)) begin
        ptr <= {addr_hi[i2cm_pkg::HI_USED_MSB:0], rx_byte};
      end else if (ptr_inc) begin
        // RULE_17 natural 13-bit wrap
        ptr <= ptr + i2cm_pkg::PTR_ONE;
      end
    end
  end

  // RULE_08 storage array
  // RULE_13 the byte at the pointer is refreshed every cycle without an array write
  // RULE_15 buffered writes drain within a cycle or two, far inside one SCL bit
  always_ff @(posedge clk) begin
    if (mem_wr) begin
      mem[drain_word.addr] <= drain_word.data;
    end else begin
      mem_q <= mem[ptr];
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_sda_low_only: assert property (sda_out == 1'b0) // RULE_04
    else $error("SDA output driven high");
  a_change_scl_low: assert property ($changed(sda_oe_n) |-> !scl_s) // RULE_03
    else $error("SDA changed while SCL high");
  a_foreign_addr: assert property (rx_last && state == i2cm_pkg::I2CM_DEVADDR && !addr_match // RULE_01
    && !start_cond && !stop_cond |=> state == i2cm_pkg::I2CM_IDLE && sda_oe_n)
    else $error("Answered a foreign slave address");
  a_protect_push: assert property (wdata_last && wp_s |=> !fifo_out_valid) // RULE_05
    else $error("Write queued while protected");
  a_commit_point: assert property (push_req |-> scl_rise && state == i2cm_pkg::I2CM_WDATA // RULE_19
    && bit_cnt == i2cm_pkg::LAST_BIT)
    else $error("Write queued away from eighth bit");
  a_ptr_wrap: assert property (ptr_inc && ptr == i2cm_pkg::PTR_LAST // RULE_17
    |=> ptr == i2cm_pkg::PTR_RESET)
    else $error("Pointer did not wrap");
  a_addr_load: assert property (rx_last && state == i2cm_pkg::I2CM_ADDRL // RULE_12
    |=> ptr == {$past(addr_hi[i2cm_pkg::HI_USED_MSB:0]), $past(rx_byte)})
    else $error("Pointer not loaded from address bytes");
  a_drain_fast: assert property ($rose(fifo_out_valid) |-> ##[1:8] !fifo_out_valid) // RULE_15
    else $error("Write buffer not drained");
  a_read_end: assert property (scl_rise && state == i2cm_pkg::I2CM_RACK && sda_s // RULE_18
    && !start_cond && !stop_cond |=> state == i2cm_pkg::I2CM_IDLE ##1 sda_oe_n)
    else $error("Read continued after no-acknowledge");
  a_ack_drive: assert property (byte_done && scl_fall && !start_cond && !stop_cond // RULE_20
    |=> state == i2cm_pkg::I2CM_ACK && !sda_oe_n)
    else $error("Byte not acknowledged");

  c_write_byte: cover property (push_req);
  c_read_ack: cover property (scl_rise && state == i2cm_pkg::I2CM_RACK && !sda_s);
  c_wrap: cover property (ptr_inc && ptr == i2cm_pkg::PTR_LAST);
  c_protected: cover property (wdata_last && wp_s);

endmodule // i2cm_top
